// File: logic/cmb_bank_if.sv
/*
  Interface between the mode controller and the register bank.
  Assumes both ends run on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface cmb_bank_if;
  import cmb_pkg::*;
  logic [2:0]  bank;
  logic        rd_compact;
  logic [3:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_en;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic        link_en;
  logic [2:0]  link_bank;
  logic [31:0] link_data;
  logic [31:0] pc;

  modport ctl  (output bank, rd_compact, rd_addr, wr_en, wr_addr, wr_data,
                output link_en, link_bank, link_data,
                input rd_data, rd_ok, pc);
  modport bank_side (input bank, rd_compact, rd_addr, wr_en, wr_addr,
                input wr_data, link_en, link_bank, link_data,
                output rd_data, rd_ok, pc);
endinterface

`default_nettype wire

// File: logic/cmb_exc_prio.sv
/*
  Fixed-priority exception selector with the abort/fast-interrupt nesting.
  Assumes requests are levels held until taken.
*/
`timescale 1ns/1ps
`default_nettype none

module cmb_exc_prio
  import cmb_pkg::*;
(
  input  wire logic     rst_req,
  input  wire logic     dabort,
  input  wire logic     fast,
  input  wire logic     normal,
  input  wire logic     pabort,
  input  wire logic     instr,
  input  wire logic     fast_masked,
  input  wire logic     normal_masked,
  output cmb_exc_t      pick,
  output logic          nest_fast
);
  wire logic fast_live   = fast && !fast_masked;
  wire logic normal_live = normal && !normal_masked;

  // Abort wins, fast interrupt follows in the next cycle when both arrive
  assign nest_fast = dabort && fast_live && !rst_req;
  assign pick = rst_req     ? CMB_EXC_RESET  :
                dabort      ? CMB_EXC_DABORT :
                fast_live   ? CMB_EXC_FAST   :
                normal_live ? CMB_EXC_NORMAL :
                pabort      ? CMB_EXC_PABORT :
                instr       ? CMB_EXC_INSTR  : CMB_EXC_NONE;
endmodule

`default_nettype wire

// File: logic/cmb_mode_ctl.sv
/*
  Core mode, banked register and exception control top.
  Assumes the pipeline presents one request per cycle, levels for exceptions.
*/
// Behaviour
// - Seven modes exist; all but user are privileged.
// - Aborts enter abort mode; undefined instruction enters undefined mode.
// - Mode changes by software write or by exception entry.
// - Storage is 31 general words plus 6 status words, 32 bits.
// - Full-width view shows r0..r15 and the current status word.
// - Link register r14 takes the return address on call with link.
// - r15 is the program counter; status holds flags and mode.
// - Fast mode banks r8..r14; other privileged modes except system bank r13, r14.
// - Banked r14 catches return address on exception or call in mode.
// - Each privileged mode except system has its own saved status word.
// - Compact state exposes r0..r7, stack pointer, link, counter, status.
// - Status holds ALU result flags, interrupt disables, mode select.
// - Status holds negative, zero, carry and overflow flags.
// - Saturation flag is sticky until a status write or a return clears it.
// - No condition code tests the saturation flag.
// - Bytecode flag selects bytecode state, else compact flag decides.
// - Mode field is five bits wide.
// - Six exception classes; trap and reset enter supervisor.
// - Entry saves into target mode's banked r14 and saved status.
// - Priority: reset, data abort, fast, normal, prefetch, instruction.
// - Breakpoint, undefined and trap never pend together.
// - Abort with fast interrupt enters abort, then fast in the next cycle.
// - Exception entry forces full-width state; return restores it.
// - Entry copies current into saved status, then forces mode.
`timescale 1ns/1ps
`default_nettype none

module cmb_mode_ctl
  import cmb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        rst_req,
  input  wire logic        dabort_req,
  input  wire logic        fast_req,
  input  wire logic        normal_req,
  input  wire logic        pabort_req,
  input  wire logic        undef_req,
  input  wire logic        brk_req,
  input  wire logic        trap_req,
  input  wire logic        flags_we,
  input  wire logic [3:0]  flags_in,
  input  wire logic        sat_set,
  input  wire logic        status_we,
  input  wire logic        status_saved,
  input  wire logic [31:0] status_wdata,
  input  wire logic        ret_req,
  input  wire logic        call_link,
  input  wire logic [31:0] return_addr,
  input  wire logic [3:0]  cond_code,
  input  wire logic [3:0]  reg_raddr,
  input  wire logic        reg_we,
  input  wire logic [3:0]  reg_waddr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  output logic [31:0]      pc,
  output logic [31:0]      current_program_status,
  output logic [31:0]      saved_program_status,
  output logic             privileged,
  output logic             exc_taken,
  output logic [2:0]       exc_kind,
  output logic             cond_pass,
  output logic             instr_conflict
);
  cmb_bank_if bi ();

  logic [31:0] status;
  logic [31:0] saved [CMB_SAVED_CNT];
  logic        fast_pending;
  cmb_exc_t    pick;
  logic        nest_fast;

  wire cmb_mode_t mode = cmb_mode_t'(status[CMB_MODE_HI:0]);

  function automatic logic [2:0] cmb_bank_of(input cmb_mode_t m);
    logic [2:0] b;
    b = CMB_BANK_USER;
    case (m)
      CMB_MODE_FAST:   b = CMB_BANK_FAST;
      CMB_MODE_NORMAL: b = CMB_BANK_NORMAL;
      CMB_MODE_SUPER:  b = CMB_BANK_SUPER;
      CMB_MODE_ABORT:  b = CMB_BANK_ABORT;
      CMB_MODE_UNDEF:  b = CMB_BANK_UNDEF;
      default:         b = CMB_BANK_USER;
    endcase
    return b;
  endfunction

  wire logic [2:0] cur_bank = cmb_bank_of(mode);
  wire logic       priv_now = mode != CMB_MODE_USER;
  wire logic       has_saved = cur_bank != CMB_BANK_USER;
  wire logic [2:0] saved_idx = 3'(cur_bank - 3'h1);
  wire logic       compact_now = !status[CMB_BIT_BYTE]
                                 && status[CMB_BIT_COMP];

  cmb_exc_prio u_prio (
    .rst_req       (rst_req),
    .dabort        (dabort_req),
    .fast          (fast_req),
    .normal        (normal_req),
    .pabort        (pabort_req),
    .instr         (undef_req | brk_req | trap_req),
    .fast_masked   (status[CMB_BIT_FIRQ]),
    .normal_masked (status[CMB_BIT_NIRQ]),
    .pick          (pick),
    .nest_fast     (nest_fast)
  );

  // Target mode per exception class
  logic [4:0] tgt_mode;
  always_comb begin
    case (fast_pending ? CMB_EXC_FAST : pick)
      CMB_EXC_RESET:  tgt_mode = CMB_MODE_SUPER;
      CMB_EXC_DABORT: tgt_mode = CMB_MODE_ABORT;
      CMB_EXC_FAST:   tgt_mode = CMB_MODE_FAST;
      CMB_EXC_NORMAL: tgt_mode = CMB_MODE_NORMAL;
      CMB_EXC_PABORT: tgt_mode = CMB_MODE_ABORT;
      CMB_EXC_INSTR:  tgt_mode = undef_req ? CMB_MODE_UNDEF :
                                 brk_req ? CMB_MODE_ABORT : CMB_MODE_SUPER;
      default:        tgt_mode = status[CMB_MODE_HI:0];
    endcase
  end

  wire logic       take      = pick != CMB_EXC_NONE || fast_pending;
  wire logic [2:0] tgt_bank  = cmb_bank_of(cmb_mode_t'(tgt_mode));
  wire logic [2:0] tgt_idx   = 3'(tgt_bank - 3'h1);
  wire logic       do_ret    = ret_req && has_saved && !take;
  wire logic       sw_write  = status_we && !take && !do_ret;

  // Exception entry: mode forced, full-width state, normal interrupt always masked, fast by kind
  logic [31:0] entry_status;
  always_comb begin
    entry_status = status;
    entry_status[CMB_MODE_HI:0] = tgt_mode;
    entry_status[CMB_BIT_COMP] = 1'b0;
    entry_status[CMB_BIT_BYTE] = 1'b0;
    entry_status[CMB_BIT_NIRQ] = 1'b1;
    if (tgt_mode == CMB_MODE_FAST || pick == CMB_EXC_RESET) begin
      entry_status[CMB_BIT_FIRQ] = 1'b1;
    end
  end

  // Software write from a non-privileged mode leaves bits 7..0 (disables, compact, mode) unchanged
  logic [31:0] sw_status;
  always_comb begin
    sw_status = status_wdata;
    if (!priv_now) begin
      sw_status[CMB_BIT_NIRQ:0] = status[CMB_BIT_NIRQ:0];
    end
  end

  logic [31:0] next_status;
  always_comb begin
    next_status = status;
    if (take) begin
      next_status = entry_status;
    end else if (do_ret) begin
      next_status = saved[saved_idx];
    end else if (sw_write && !status_saved) begin
      next_status = sw_status;
    end else if (flags_we) begin
      next_status[CMB_BIT_NEG:CMB_BIT_OVF] = flags_in;
    end
    if (sat_set && !take && !do_ret) begin
      next_status[CMB_BIT_SAT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      status <= CMB_STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  genvar gs;
  for (gs = 0; gs < CMB_SAVED_CNT; gs++) begin : g_saved
    always_ff @(posedge clk) begin
      if (reset) begin
        saved[gs] <= 32'h00000000;
      end else if (take && tgt_idx == 3'(gs)) begin
        saved[gs] <= status;
      end else if (sw_write && status_saved && has_saved
                   && saved_idx == 3'(gs)) begin
        saved[gs] <= status_wdata;
      end
    end
  end

  // Fast interrupt follows in the cycle after an abort entry
  always_ff @(posedge clk) begin
    if (reset) begin
      fast_pending <= 1'b0;
    end else begin
      fast_pending <= nest_fast && !fast_pending;
    end
  end

  assign bi.bank       = cur_bank;
  assign bi.rd_compact = compact_now;
  assign bi.rd_addr    = reg_raddr;
  assign bi.wr_en      = reg_we && !take;
  assign bi.wr_addr    = reg_waddr;
  assign bi.wr_data    = reg_wdata;
  assign bi.link_en    = take || call_link;
  assign bi.link_bank  = take ? tgt_bank : cur_bank;
  assign bi.link_data  = return_addr;

  cmb_reg_bank u_bank (
    .clk   (clk),
    .reset (reset),
    .bi    (bi)
  );

  // Condition codes: 0..E over N Z C V only, never the saturation bit
  logic cond_now;
  wire logic fn = status[CMB_BIT_NEG];
  wire logic fz = status[CMB_BIT_ZERO];
  wire logic fc = status[CMB_BIT_CARRY];
  wire logic fv = status[CMB_BIT_OVF];
  always_comb begin
    case (cond_code)
      4'h0:    cond_now = fz;
      4'h1:    cond_now = !fz;
      4'h2:    cond_now = fc;
      4'h3:    cond_now = !fc;
      4'h4:    cond_now = fn;
      4'h5:    cond_now = !fn;
      4'h6:    cond_now = fv;
      4'h7:    cond_now = !fv;
      4'h8:    cond_now = fc && !fz;
      4'h9:    cond_now = !fc || fz;
      4'hA:    cond_now = fn == fv;
      4'hB:    cond_now = fn != fv;
      4'hC:    cond_now = !fz && fn == fv;
      4'hD:    cond_now = fz || fn != fv;
      4'hE:    cond_now = 1'b1;
      default: cond_now = 1'b0;
    endcase
  end

  wire logic conflict_now = (undef_req && brk_req) || (undef_req && trap_req)
                            || (brk_req && trap_req);

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata              <= 32'h00000000;
      reg_rvalid             <= 1'b0;
      pc                     <= 32'h00000000;
      current_program_status <= CMB_STATUS_RESET;
      saved_program_status   <= 32'h00000000;
      privileged             <= 1'b1;
      exc_taken              <= 1'b0;
      exc_kind               <= 3'h0;
      cond_pass              <= 1'b0;
      instr_conflict         <= 1'b0;
    end else begin
      reg_rdata              <= bi.rd_data;
      reg_rvalid             <= bi.rd_ok;
      pc                     <= bi.pc;
      current_program_status <= status;
      saved_program_status   <= has_saved ? saved[saved_idx] : 32'h00000000;
      privileged             <= priv_now;
      exc_taken              <= take;
      exc_kind               <= fast_pending ? 3'(CMB_EXC_FAST) : 3'(pick);
      cond_pass              <= cond_now;
      instr_conflict         <= conflict_now;
    end
  end
endmodule

`default_nettype wire

// File: logic/cmb_pkg.sv
/*
  Package for the core mode, register bank and exception control block.
  Assumes one core clock; all users import the whole package.
*/
`default_nettype none

package cmb_pkg;

  typedef enum logic [4:0] {
    CMB_MODE_USER   = 5'h10,
    CMB_MODE_FAST   = 5'h11,
    CMB_MODE_NORMAL = 5'h12,
    CMB_MODE_SUPER  = 5'h13,
    CMB_MODE_ABORT  = 5'h17,
    CMB_MODE_UNDEF  = 5'h1B,
    CMB_MODE_SYSTEM = 5'h1F
  } cmb_mode_t;

  localparam int CMB_WORD       = 32;
  localparam int CMB_BANK_COUNT = 6;
  localparam int CMB_SAVED_CNT  = 5;
  localparam int CMB_PHYS_REGS  = 31;

  localparam int CMB_BIT_NEG    = 31;
  localparam int CMB_BIT_ZERO   = 30;
  localparam int CMB_BIT_CARRY  = 29;
  localparam int CMB_BIT_OVF    = 28;
  localparam int CMB_BIT_SAT    = 27;
  localparam int CMB_BIT_BYTE   = 24;
  localparam int CMB_BIT_NIRQ   = 7;
  localparam int CMB_BIT_FIRQ   = 6;
  localparam int CMB_BIT_COMP   = 5;
  localparam int CMB_MODE_HI    = 4;

  localparam logic [31:0] CMB_STATUS_RESET = 32'h000000D3;

  localparam logic [3:0] CMB_REG_FAST_LO = 4'h8;
  localparam logic [3:0] CMB_REG_SP      = 4'hD;
  localparam logic [3:0] CMB_REG_LINK    = 4'hE;
  localparam logic [3:0] CMB_REG_PC      = 4'hF;
  localparam logic [3:0] CMB_REG_COMPACT_HI = 4'h7;

  localparam logic [2:0] CMB_BANK_USER   = 3'h0;
  localparam logic [2:0] CMB_BANK_FAST   = 3'h1;
  localparam logic [2:0] CMB_BANK_NORMAL = 3'h2;
  localparam logic [2:0] CMB_BANK_SUPER  = 3'h3;
  localparam logic [2:0] CMB_BANK_ABORT  = 3'h4;
  localparam logic [2:0] CMB_BANK_UNDEF  = 3'h5;

  typedef enum logic [2:0] {
    CMB_EXC_NONE,
    CMB_EXC_RESET,
    CMB_EXC_DABORT,
    CMB_EXC_FAST,
    CMB_EXC_NORMAL,
    CMB_EXC_PABORT,
    CMB_EXC_INSTR
  } cmb_exc_t;

endpackage

`default_nettype wire

// File: logic/cmb_reg_bank.sv
/*
  Banked general register store: 31 physical words behind a 16-word view.
  Assumes the controller resolves the bank from the mode field.
*/
`timescale 1ns/1ps
`default_nettype none

module cmb_reg_bank
  import cmb_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  cmb_bank_if.bank_side bi
);
  // 0..7 shared, 8..12 user, 13..17 fast r8..r12, 18+2b sp/link per bank
  logic [31:0] phys [CMB_PHYS_REGS];

  function automatic logic [4:0] cmb_map(input logic [2:0] b,
                                         input logic [3:0] a);
    logic [4:0] r;
    r = {1'b0, a};
    if (a == CMB_REG_SP || a == CMB_REG_LINK) begin
      r = 5'(18 + 2 * b + (a - CMB_REG_SP));
    end else if (b == CMB_BANK_FAST && a >= CMB_REG_FAST_LO) begin
      r = 5'(a + 5);
    end
    return r;
  endfunction

  wire logic [4:0] rd_phys   = cmb_map(bi.bank, bi.rd_addr);
  wire logic [4:0] wr_phys   = cmb_map(bi.bank, bi.wr_addr);
  wire logic [4:0] link_phys = cmb_map(bi.link_bank, CMB_REG_LINK);
  wire logic       rd_pc     = bi.rd_addr == CMB_REG_PC;
  wire logic       rd_hidden = bi.rd_compact && bi.rd_addr > CMB_REG_COMPACT_HI
                               && bi.rd_addr < CMB_REG_SP;
  wire logic       wr_pc     = bi.wr_en && bi.wr_addr == CMB_REG_PC;

  assign bi.rd_ok   = !rd_hidden;
  assign bi.rd_data = rd_hidden ? 32'h00000000 :
                      rd_pc ? bi.pc : phys[rd_phys];

  always_ff @(posedge clk) begin
    if (reset) begin
      bi.pc <= 32'h00000000;
    end else if (wr_pc) begin
      bi.pc <= bi.wr_data;
    end
  end

  genvar gi;
  for (gi = 0; gi < CMB_PHYS_REGS; gi++) begin : g_reg
    always_ff @(posedge clk) begin
      if (bi.link_en && link_phys == 5'(gi)) begin
        phys[gi] <= bi.link_data;
      end else if (bi.wr_en && !wr_pc && wr_phys == 5'(gi)) begin
        phys[gi] <= bi.wr_data;
      end
    end
  end
endmodule

`default_nettype wire

// File: tb/cmb_mode_ctl_sva.sv
/*
  Port checker for cmb_mode_ctl, bound to every instance.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module cmb_mode_ctl_sva
  import cmb_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        rst_req,
  input wire logic        dabort_req,
  input wire logic        status_we,
  input wire logic        ret_req,
  input wire logic [3:0]  cond_code,
  input wire logic [31:0] pc,
  input wire logic [31:0] current_program_status,
  input wire logic [31:0] saved_program_status,
  input wire logic        privileged,
  input wire logic        exc_taken,
  input wire logic [2:0]  exc_kind,
  input wire logic        cond_pass
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic [4:0] md = current_program_status[4:0];
  logic      [2:0] since;
  // Cycles since the last event allowed to clear saturation
  always_ff @(posedge clk) begin
    if (reset || status_we || ret_req || rst_req)
      since <= 3'h0;
    else if (since != 3'h7)
      since <= since + 3'h1;
  end
  sequence s_dab;
    exc_taken && exc_kind == CMB_EXC_DABORT;
  endsequence
  sequence s_fast;
    exc_taken && exc_kind == CMB_EXC_FAST;
  endsequence
  sequence s_rst;
    exc_taken && exc_kind == CMB_EXC_RESET;
  endsequence
  property p_rst_val;
    $fell(reset) |-> current_program_status == CMB_STATUS_RESET &&
      pc == 32'h0 && saved_program_status == 32'h0 && privileged;
  endproperty
  property p_mode_code;
    md inside {CMB_MODE_USER, CMB_MODE_FAST, CMB_MODE_NORMAL, CMB_MODE_SUPER,
               CMB_MODE_ABORT, CMB_MODE_UNDEF, CMB_MODE_SYSTEM};
  endproperty
  property p_priv;
    $stable(md) [*3] |-> privileged == (md != CMB_MODE_USER);
  endproperty
  property p_kind;
    exc_taken |-> exc_kind != CMB_EXC_NONE && exc_kind <= CMB_EXC_INSTR;
  endproperty
  property p_rst_exc;
    rst_req |-> ##[1:4] s_rst;
  endproperty
  property p_dab;
    dabort_req && !rst_req |-> ##[1:4] s_dab;
  endproperty
  property p_nest;
    s_dab ##1 s_fast |-> ##[0:3] md == CMB_MODE_FAST;
  endproperty
  property p_never;
    cond_code == 4'hF |=> !cond_pass;
  endproperty
  property p_sticky;
    $fell(current_program_status[CMB_BIT_SAT]) |-> since < 3'h5;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("reset values wrong");
  a_mode_code: assert property (p_mode_code)
    else $error("mode field holds no mode code");
  a_priv: assert property (p_priv)
    else $error("privileged flag disagrees with mode");
  a_kind: assert property (p_kind)
    else $error("entry with no exception class");
  a_rst_exc: assert property (p_rst_exc)
    else $error("reset request not taken first");
  a_dab: assert property (p_dab)
    else $error("data abort not taken first");
  a_nest: assert property (p_nest)
    else $error("nested fast entry left wrong mode");
  a_never: assert property (p_never)
    else $error("never condition passed");
  a_sticky: assert property (p_sticky)
    else $error("saturation flag cleared on its own");
endmodule

bind cmb_mode_ctl cmb_mode_ctl_sva u_sva (
  .clk, .reset, .rst_req, .dabort_req, .status_we, .ret_req, .cond_code,
  .pc, .current_program_status, .saved_program_status, .privileged,
  .exc_taken, .exc_kind, .cond_pass
);

`default_nettype wire

// File: tb/tb.sv
/*
  Self-checking bench for cmb_mode_ctl: exceptions, banking, status word.
  Assumes the port checker is bound from its own file.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import cmb_pkg::*;
  logic        clk          = 1'b0;
  logic        reset        = 1'b1;
  logic [7:0]  req          = 8'h00;
  logic        flags_we     = 1'b0;
  logic [3:0]  flags_in     = 4'h0;
  logic        sat_set      = 1'b0;
  logic        status_we    = 1'b0;
  logic        status_saved = 1'b0;
  logic [31:0] status_wdata = 32'h0;
  logic        ret_req      = 1'b0;
  logic        call_link    = 1'b0;
  logic [31:0] return_addr  = 32'h0;
  logic [3:0]  cond_code    = 4'h0;
  logic [3:0]  reg_raddr    = 4'h0;
  logic        reg_we       = 1'b0;
  logic [3:0]  reg_waddr    = 4'h0;
  logic [31:0] reg_wdata    = 32'h0;
  logic [31:0] reg_rdata, pc, cps, sps;
  logic        reg_rvalid, privileged, exc_taken, cond_pass, instr_conflict;
  logic [2:0]  exc_kind;
  logic [31:0] seed         = 32'hA10C;
  int          n_errors     = 0;
  int          checks       = 0;
  int          cyc          = 0;
  cmb_exc_t    expq[$];
  // Request bits: reset, data abort, fast, normal, prefetch, undef, brk, trap
  logic [7:0]  tv [13] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02, 8'h01, 8'h10,
                           8'h20, 8'hE0, 8'h18, 8'h0C, 8'h30, 8'h60};
  cmb_exc_t    tk [13] = '{CMB_EXC_RESET, CMB_EXC_DABORT, CMB_EXC_PABORT,
    CMB_EXC_INSTR, CMB_EXC_INSTR, CMB_EXC_INSTR, CMB_EXC_NORMAL, CMB_EXC_FAST,
    CMB_EXC_RESET, CMB_EXC_NORMAL, CMB_EXC_PABORT, CMB_EXC_FAST,
    CMB_EXC_DABORT};
  cmb_mode_t   tm [13] = '{CMB_MODE_SUPER, CMB_MODE_ABORT, CMB_MODE_ABORT,
    CMB_MODE_UNDEF, CMB_MODE_ABORT, CMB_MODE_SUPER, CMB_MODE_NORMAL,
    CMB_MODE_FAST, CMB_MODE_SUPER, CMB_MODE_NORMAL, CMB_MODE_ABORT,
    CMB_MODE_FAST, CMB_MODE_FAST};
  logic [31:0] ms [3]  = '{32'h000000DF, 32'h000000D1, 32'h000000D3};

  always #5 clk = ~clk;

  cmb_mode_ctl dut (
    .clk, .reset, .rst_req(req[7]), .dabort_req(req[6]), .fast_req(req[5]),
    .normal_req(req[4]), .pabort_req(req[3]), .undef_req(req[2]),
    .brk_req(req[1]), .trap_req(req[0]), .flags_we, .flags_in, .sat_set,
    .status_we, .status_saved, .status_wdata, .ret_req, .call_link,
    .return_addr, .cond_code, .reg_raddr, .reg_we, .reg_waddr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .pc, .current_program_status(cps),
    .saved_program_status(sps), .privileged, .exc_taken, .exc_kind,
    .cond_pass, .instr_conflict
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected banked word for mode slot m and register r
  function automatic logic [31:0] bx(input int m, input int r);
    if (m == 1)
      return 32'h200 + r;
    if (m == 2 && r > 12)
      return 32'h300 + r;
    return 32'h100 + r;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wstat(input logic [31:0] v, input logic s);
    status_we    <= 1'b1;
    status_wdata <= v;
    sat_set      <= s;
    @(posedge clk);
    status_we    <= 1'b0;
    sat_set      <= 1'b0;
    tick(3);
  endtask
  task automatic ret();
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    tick(4);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    reg_we    <= 1'b1;
    reg_waddr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    reg_raddr <= a;
    tick(2);
    check("reg", reg_rdata, e);
  endtask
  task automatic alu(input logic [3:0] f, input logic s);
    flags_we <= 1'b1;
    flags_in <= f;
    sat_set  <= s;
    @(posedge clk);
    flags_we <= 1'b0;
    sat_set  <= 1'b0;
    tick(4);
  endtask

  always @(posedge clk) begin
    if (!reset && exc_taken === 1'b1) begin
      // An entry with nothing expected is itself a mismatch
      if (expq.size() > 0)
        check("exc_kind", 32'(exc_kind), 32'(expq.pop_front()));
      else
        check("exc_kind", 32'(exc_kind), 32'(CMB_EXC_NONE));
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    tick(2);
    check("status", cps, CMB_STATUS_RESET);
    check("saved", sps, 32'h0);
    for (int i = 0; i < 13; i++) begin
      wstat(32'h00000033, 1'b0);
      seed = lfsr(seed);
      return_addr <= seed;
      req <= tv[i];
      expq.push_back(tk[i]);
      if (i == 12)
        expq.push_back(CMB_EXC_FAST);
      @(posedge clk);
      req <= 8'h00;
      tick(6);
      check("mode", 32'(cps[4:0]), 32'(tm[i]));
      check("full", 32'(cps[CMB_BIT_COMP]), 32'h0);
      if (tk[i] != CMB_EXC_RESET && i != 12) begin
        check("saved", sps, 32'h33);
        rreg(CMB_REG_LINK, seed);
        ret();
        check("back", cps, 32'h33);
      end
    end
    // Fast handler holds the abort handler's status; return resumes abort
    check("nested", sps, 32'h00000097);
    ret();
    check("resume", 32'(cps[4:0]), 32'(CMB_MODE_ABORT));
    seed = lfsr(seed);
    alu(seed[3:0], 1'b1);
    check("flags", 32'(cps[31:27]), 32'({seed[3:0], 1'b1}));
    alu(~seed[3:0], 1'b0);
    check("sticky", 32'(cps[31:27]), 32'({~seed[3:0], 1'b1}));
    cond_code <= 4'hE;
    tick(2);
    check("cond", 32'(cond_pass), 32'h1);
    cond_code <= 4'hF;
    tick(2);
    check("cond", 32'(cond_pass), 32'h0);
    wstat(32'h00000013, 1'b1);
    check("sat", 32'(cps[CMB_BIT_SAT]), 32'h1);
    wstat(32'h00000013, 1'b0);
    check("sat", 32'(cps[CMB_BIT_SAT]), 32'h0);
    seed = lfsr(seed);
    return_addr <= seed;
    call_link   <= 1'b1;
    @(posedge clk);
    call_link   <= 1'b0;
    rreg(CMB_REG_LINK, seed);
    seed = lfsr(seed);
    wreg(CMB_REG_PC, seed);
    reg_we <= 1'b0;
    tick(2);
    check("pc", pc, seed);
    rreg(CMB_REG_PC, seed);
    for (int m = 0; m < 3; m++) begin
      wstat(ms[m], 1'b0);
      for (int r = 8; r < 15; r++)
        if (m != 2 || r > 12)
          wreg(4'(r), bx(m, r));
      reg_we <= 1'b0;
    end
    for (int m = 0; m < 3; m++) begin
      wstat(ms[m], 1'b0);
      for (int r = 8; r < 15; r++)
        rreg(4'(r), bx(m, r));
    end
    wstat(32'h000000F3, 1'b0);
    for (int r = 6; r < 10; r++) begin
      reg_raddr <= 4'(r);
      tick(2);
      check("visible", 32'(reg_rvalid), 32'(r < 8));
    end
    // Bytecode state overrides the compact flag, so r8 is visible again
    wstat(32'h010000F3, 1'b0);
    reg_raddr <= CMB_REG_FAST_LO;
    tick(2);
    check("bytecode", 32'(reg_rvalid), 32'h1);
    wstat(32'h00000010, 1'b0);
    check("priv", 32'(privileged), 32'h0);
    check("saved", sps, 32'h0);
    wstat(32'h0000001F, 1'b0);
    ret();
    check("user", 32'(cps[4:0]), 32'h10);
    // Two instruction exceptions at once must be flagged
    req <= 8'h03;
    expq.push_back(CMB_EXC_INSTR);
    @(posedge clk);
    req <= 8'h00;
    @(posedge clk);
    check("conflict", 32'(instr_conflict), 32'h1);
    req <= 8'h80;
    expq.push_back(CMB_EXC_RESET);
    @(posedge clk);
    req <= 8'h00;
    tick(6);
    check("priv", 32'(privileged), 32'h1);
    check("pending", 32'(expq.size()), 32'h0);
    summarize();
  end
endmodule

`default_nettype wire
